// ===== flrc_regs.sv
// loop ratio configuration registers behind an axi4-lite slave
//
// How it works
// - the output divider field in bits 13:8 divides the oscillator clock by code plus one (4 to 64).
// - the control block rate field in bits 6:4 divides the oscillator clock by code plus one (1 to 8).
// - the ratio field in bits 2:0 divides by 1, 2, 4, 8, or 16 for any code with bit 2 set, reset 111.
// - the 16-bit fractional multiply is an unsigned fraction with msb weight one half, reset zero.
// - the 10-bit integer multiply in bits 14:5 has lsb weight one, reset 01_0111_0111.
// - the gain field in bits 3:0 scales the error by two to the code, 1 to 256, codes above 8 held at 256, reset times 1.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module flrc_regs (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // axi4-lite write address and data
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    // axi4-lite write response
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // configuration to the loop
    output flrc_pkg::flrc_cfg_t o_cfg,
    output flrc_pkg::flrc_derived_t o_derived
);
    // ****************************************
    // functions
    // ****************************************
    // merge byte lanes of a write into an old word
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd, input logic [3:0] st);
        logic [15:0] r;
        r = old_v;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    function automatic logic is_mapped(input logic [31:0] a);
        return (a[31:10] == 22'h00_0000) && (a[9:0] == flrc_pkg::ADDR_DIVIDER || a[9:0] == flrc_pkg::ADDR_FRACTION
            || a[9:0] == flrc_pkg::ADDR_INTEGER);
    endfunction : is_mapped

    // ****************************************
    // state
    // ****************************************
    logic [5:0] outdiv_reg;
    logic [2:0] ctrlrate_reg;
    logic [2:0] ratio_reg;
    logic [15:0] frac_reg;
    logic [9:0] intmul_reg;
    logic [3:0] gain_reg;
    logic aw_held_reg;
    logic [31:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    // ****************************************
    // bus decode
    // ****************************************
    // one write outstanding: address and data each held until both arrive
    wire aw_take = i_awvalid && o_awready;
    wire w_take = i_wvalid && o_wready;
    wire [31:0] wr_addr = aw_held_reg ? aw_addr_reg : i_awaddr;
    wire [31:0] wr_data = w_held_reg ? w_data_reg : i_wdata;
    wire [3:0] wr_strb = w_held_reg ? w_strb_reg : i_wstrb;
    wire have_aw = aw_held_reg || aw_take;
    wire have_w = w_held_reg || w_take;
    wire wr_fire = have_aw && have_w && !bvalid_reg;
    wire [9:0] wa = wr_addr[9:0];
    wire wr_ok = is_mapped(wr_addr);
    wire wr_div = wr_fire && wr_ok && wa == flrc_pkg::ADDR_DIVIDER;
    wire wr_frac = wr_fire && wr_ok && wa == flrc_pkg::ADDR_FRACTION;
    wire wr_int = wr_fire && wr_ok && wa == flrc_pkg::ADDR_INTEGER;
    assign o_awready = !aw_held_reg && !bvalid_reg;
    assign o_wready = !w_held_reg && !bvalid_reg;
    assign o_arready = !rvalid_reg;
    wire rd_take = i_arvalid && o_arready;

    // register images; unassigned bits are zero
    wire [15:0] img_div = {2'b00, outdiv_reg, 1'b0, ctrlrate_reg, 1'b0, ratio_reg};
    wire [15:0] img_int = {1'b0, intmul_reg, 1'b0, gain_reg};
    wire [15:0] new_div = merge16(img_div, wr_data, wr_strb);
    wire [15:0] new_frac = merge16(frac_reg, wr_data, wr_strb);
    wire [15:0] new_int = merge16(img_int, wr_data, wr_strb);
    wire [9:0] ra = i_araddr[9:0];
    wire [15:0] rd_word = !is_mapped(i_araddr) ? 16'h0000 :
        (ra == flrc_pkg::ADDR_DIVIDER) ? img_div :
        (ra == flrc_pkg::ADDR_FRACTION) ? frac_reg : img_int;

    // ****************************************
    // channel handshake
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 32'h0000_0000;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= flrc_pkg::RESP_OKAY;
        end else begin
            if (aw_take && !wr_fire) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= i_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take && !wr_fire) begin
                w_held_reg <= 1'b1;
                w_data_reg <= i_wdata;
                w_strb_reg <= i_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? flrc_pkg::RESP_OKAY : flrc_pkg::RESP_SLVERR;
            end else if (i_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= flrc_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= is_mapped(i_araddr) ? flrc_pkg::RESP_OKAY : flrc_pkg::RESP_SLVERR;
            rdata_reg <= {16'h0000, rd_word};
        end else if (i_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ****************************************
    // configuration fields
    // ****************************************
    // reserved divider codes are stored as written; keeping them off is software's job
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            outdiv_reg <= flrc_pkg::OUTDIV_RST;
            ctrlrate_reg <= flrc_pkg::CTRLRATE_RST;
            ratio_reg <= flrc_pkg::RATIO_RST;
            frac_reg <= flrc_pkg::FRAC_RST;
            intmul_reg <= flrc_pkg::INTMUL_RST;
            gain_reg <= flrc_pkg::GAIN_RST;
        end else begin
            if (wr_div) begin
                outdiv_reg <= new_div[flrc_pkg::OUTDIV_LSB +: 6];
                ctrlrate_reg <= new_div[flrc_pkg::CTRLRATE_LSB +: 3];
                ratio_reg <= new_div[flrc_pkg::RATIO_LSB +: 3];
            end
            if (wr_frac) begin
                frac_reg <= new_frac;
            end
            if (wr_int) begin
                intmul_reg <= new_int[flrc_pkg::INTMUL_LSB +: 10];
                gain_reg <= new_int[flrc_pkg::GAIN_LSB +: 4];
            end
        end
    end

    // ****************************************
    // outputs to the loop
    // ****************************************
    // divide factors decoded from flops so the loop sees stable values
    assign o_cfg = '{outdiv_reg, ctrlrate_reg, ratio_reg, frac_reg, intmul_reg, gain_reg};
    // one driver for the whole struct, member by member in declaration order
    assign o_derived = '{
        {1'b0, outdiv_reg} + 7'd1,
        {1'b0, ctrlrate_reg} + 4'd1,
        ratio_reg[2] ? 5'd16 : (5'd1 << ratio_reg[1:0]),
        (gain_reg > 4'd8) ? 9'd256 : (9'd1 << gain_reg)
    };
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rresp = rresp_reg;
    assign o_rdata = rdata_reg;

    // ****************************************
    // checks
    // ****************************************
    chk_ratio_sixteen: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        ratio_reg[2] |-> o_derived.ratio_divide == 5'd16) else $error("ratio divide not 16");
    chk_outdiv_plus: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wr_div |=> o_derived.output_divide == {1'b0, $past(new_div[13:8])} + 7'd1) else $error("outdiv wrong");
    chk_rate_plus: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wr_div |=> o_derived.control_divide == {1'b0, $past(new_div[6:4])} + 4'd1) else $error("rate wrong");
    chk_frac_store: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wr_frac |=> frac_reg == $past(new_frac)) else $error("fraction not stored");
    chk_int_store: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wr_int |=> intmul_reg == $past(new_int[14:5])) else $error("integer not stored");
    chk_gain_pow: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        gain_reg <= 4'd8 |-> o_derived.gain_factor == (9'd1 << gain_reg)) else $error("gain wrong");
    chk_read_zeros: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        rd_take |=> o_rvalid && o_rdata[31:16] == 16'h0000 && o_rdata[15] == 1'b0) else $error("read bits");
    chk_stable_noacc: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !wr_fire |=> $stable(outdiv_reg) && $stable(frac_reg) && $stable(gain_reg)) else $error("field changed");
endmodule : flrc_regs

// ===== flrc_pkg.sv
// package for the loop ratio configuration registers
package flrc_pkg;
    // ****************************************
    // register map, byte addresses (index times four)
    // ****************************************
    localparam logic [7:0] IDX_DIVIDER = 8'h75;
    localparam logic [7:0] IDX_FRACTION = 8'h76;
    localparam logic [7:0] IDX_INTEGER = 8'h77;
    localparam logic [9:0] ADDR_DIVIDER = {IDX_DIVIDER, 2'b00};
    localparam logic [9:0] ADDR_FRACTION = {IDX_FRACTION, 2'b00};
    localparam logic [9:0] ADDR_INTEGER = {IDX_INTEGER, 2'b00};
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int OUTDIV_LSB = 8;
    localparam int CTRLRATE_LSB = 4;
    localparam int RATIO_LSB = 0;
    localparam int INTMUL_LSB = 5;
    localparam int GAIN_LSB = 0;
    localparam logic [5:0] OUTDIV_RST = 6'h00;
    localparam logic [2:0] CTRLRATE_RST = 3'h0;
    localparam logic [2:0] RATIO_RST = 3'h7;
    localparam logic [15:0] FRAC_RST = 16'h0000;
    localparam logic [9:0] INTMUL_RST = 10'h177;
    localparam logic [3:0] GAIN_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [5:0] output_clock_divider;
        logic [2:0] control_block_rate;
        logic [2:0] oscillator_side_ratio;
        logic [15:0] fractional_multiply;
        logic [9:0] integer_multiply;
        logic [3:0] loop_error_gain;
    } flrc_cfg_t;
    typedef struct packed {
        logic [6:0] output_divide;   // oscillator divide, 4..64
        logic [3:0] control_divide;  // control block divide, 1..8
        logic [4:0] ratio_divide;    // 1,2,4,8,16
        logic [8:0] gain_factor;     // 1..256
    } flrc_derived_t;
endpackage : flrc_pkg

// ===== test_fll_ratio_config_regs.sv
// self-checking bench for the loop ratio configuration registers
`timescale 1ns/1ps
module test_fll_ratio_config_regs;
    // ****************************************
    // signals and design
    // ****************************************
    logic i_core_clk, i_rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr;
    logic [3:0] wstrb;
    logic [5:0] c;
    logic [3:0] g;
    logic [9:0] n;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    flrc_pkg::flrc_cfg_t cfg;
    flrc_pkg::flrc_derived_t der;
    int errors, compares;
    flrc_regs dut_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .o_cfg(cfg), .o_derived(der));
    // ****************************************
    // bus tasks and comparison
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    // each channel held until its own ready; only the watchdog ends a wait
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        @(posedge i_core_clk);
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge i_core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        check(bresp, er, "write response");
    endtask : axi_write
    task automatic axi_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge i_core_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge i_core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        check(rresp, er, "read response");
        check(rdata, ed, "read data");
    endtask : axi_read
    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // ****************************************
    // clock, watchdog and tests
    // ****************************************
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // generous span: the tests need under two thousand cycles
    initial begin
        repeat (20000) @(posedge i_core_clk);
        errors++;
        wrap_up();
    end
    initial begin
        i_rst_b = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = '0; wdata = '0; araddr = '0; wstrb = '0; errors = 0; compares = 0;
        repeat (20) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        axi_read(flrc_pkg::ADDR_DIVIDER, 32'h0000_0007, flrc_pkg::RESP_OKAY);
        axi_read(flrc_pkg::ADDR_FRACTION, 32'h0000_0000, flrc_pkg::RESP_OKAY);
        axi_read(flrc_pkg::ADDR_INTEGER, 32'h0000_2EE0, flrc_pkg::RESP_OKAY);
        check(der.ratio_divide, 32'h0000_0010, "reset ratio");
        check(der.gain_factor, 32'h0000_0001, "reset gain");
        check(der.control_divide, 32'h0000_0001, "reset rate");
        $display("test reset values done");
        // codes 0 to 2 of the divider are never offered
        for (int i = 3; i < 64; i++) begin
            c = 6'(i);
            axi_write(flrc_pkg::ADDR_DIVIDER, {16'hFFFF, 2'b11, c, 1'b1, c[2:0], 1'b1, c[2:0]}, 4'hF,
                flrc_pkg::RESP_OKAY);
            check(der.output_divide, c + 1, "output divide");
            check(der.control_divide, c[2:0] + 1, "control divide");
            check(der.ratio_divide, c[2] ? 16 : 1 << c[1:0], "ratio divide");
            check(cfg.output_clock_divider, c, "divider field");
            check(cfg.oscillator_side_ratio, c[2:0], "ratio field");
            axi_read(flrc_pkg::ADDR_DIVIDER, {18'h0_0000, c, 1'b0, c[2:0], 1'b0, c[2:0]}, flrc_pkg::RESP_OKAY);
        end
        $display("test divider fields done");
        for (int i = 0; i < 9; i++) begin
            g = 4'(i);
            n = 10'h3C0 | 10'(i);
            axi_write(flrc_pkg::ADDR_INTEGER, {16'hFFFF, 1'b1, n, 1'b1, g}, 4'hF, flrc_pkg::RESP_OKAY);
            check(der.gain_factor, 1 << g, "gain factor");
            check(cfg.integer_multiply, n, "integer multiply");
            check(cfg.loop_error_gain, g, "gain field");
            axi_read(flrc_pkg::ADDR_INTEGER, {17'h0_0000, n, 1'b0, g}, flrc_pkg::RESP_OKAY);
        end
        $display("test gain and integer done");
        axi_write(flrc_pkg::ADDR_FRACTION, 32'hFFFF_8001, 4'hF, flrc_pkg::RESP_OKAY);
        check(cfg.fractional_multiply, 32'h0000_8001, "fraction");
        // only the upper byte lane is strobed here
        axi_write(flrc_pkg::ADDR_FRACTION, 32'h0000_3C55, 4'b0010, flrc_pkg::RESP_OKAY);
        axi_read(flrc_pkg::ADDR_FRACTION, 32'h0000_3C01, flrc_pkg::RESP_OKAY);
        $display("test fraction done");
        axi_write(32'h0000_0200, 32'h0000_FFFF, 4'hF, flrc_pkg::RESP_SLVERR);
        axi_write(32'h0001_01D4, 32'h0000_0000, 4'hF, flrc_pkg::RESP_SLVERR);
        axi_read(32'h0000_0200, 32'h0000_0000, flrc_pkg::RESP_SLVERR);
        axi_read(flrc_pkg::ADDR_DIVIDER, 32'h0000_3F77, flrc_pkg::RESP_OKAY);
        $display("test unmapped access done");
        // leave the loop as recommended: default rate and gain, ratio for a fast reference
        axi_write(flrc_pkg::ADDR_DIVIDER, 32'h0000_3F00, 4'hF, flrc_pkg::RESP_OKAY);
        check(cfg.oscillator_side_ratio, 32'h0000_0000, "ratio for fast reference");
        check(cfg.control_block_rate, 32'h0000_0000, "default rate");
        axi_write(flrc_pkg::ADDR_INTEGER, 32'h0000_2EE0, 4'hF, flrc_pkg::RESP_OKAY);
        check(der.gain_factor, 32'h0000_0001, "default gain");
        $display("test recommended settings done");
        // a second reset in mid-run must bring every field back to its default
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        axi_read(flrc_pkg::ADDR_DIVIDER, 32'h0000_0007, flrc_pkg::RESP_OKAY);
        axi_read(flrc_pkg::ADDR_INTEGER, 32'h0000_2EE0, flrc_pkg::RESP_OKAY);
        axi_read(flrc_pkg::ADDR_FRACTION, 32'h0000_0000, flrc_pkg::RESP_OKAY);
        $display("test reset in mid-run done");
        wrap_up();
    end
endmodule : test_fll_ratio_config_regs
